// >>> fe_consts.svh
// Offsets, field positions, reset values and thresholds of the frontend pin block
`ifndef FE_CONSTS_SVH
`define FE_CONSTS_SVH
`define OFF_AUX0 4'h0
`define OFF_PAD0 4'h4
`define OFF_AUX1 4'h8
`define OFF_PAD1 4'hC
`define AUX_BYP 7
`define AUX_MAP_HI 6
`define AUX_MAP_LO 5
`define AUX_EXT 4
`define AUX_ANALOG_REGULATOR_ENABLE 3
`define AUX_AVS 2
`define AUX_AMPLIFIER_SUPPLY_SELECT_HI 1
`define AUX_AMPLIFIER_SUPPLY_SELECT_LO 0
`define PAD_CFG_HI 7
`define PAD_CFG_LO 6
`define PAD_CFG_RST 2'h0
`define BYP_RST 1'h0
`define MAP_RST 2'h0
`define EXT_RST 1'h0
`define ANALOG_REGULATOR_ENABLE_RST 1'h0
`define AMPLIFIER_SUPPLY_SELECT_RST 2'h2
`define MAP_NONE 2'h0
`define MAP_9DB 2'h1
`define MAP_12DB 2'h2
`define GAIN_9DB 8'h09
`define GAIN_12DB 8'h0C
`define GAIN_0DB 8'h00
`define GCW_LIMIT 7'h11
`define GCW_RST 7'h7F
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> fe_pkg.sv
// Types shared by the frontend pin block
package fe_pkg;
	typedef enum logic [2:0] {
		st_idle = 3'h0,
		st_sleep = 3'h1,
		st_reset = 3'h2,
		st_transmit_prepare_state = 3'h3,
		st_tx = 3'h4,
		st_rx = 3'h5
	} radio_state_t;
	typedef enum logic [1:0] {
		pin_config_none = 2'h0,
		pin_config_one = 2'h1,
		pin_config_two = 2'h2,
		pin_config_three = 2'h3
	} pin_cfg_t;
endpackage

// >>> rf_frontend_pin_control.sv
// Frontend pin control, gain mapping and auxiliary settings for two transceivers
`include "fe_consts.svh"
module rf_frontend_pin_control (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [5:0] radio_state,
	input wire logic [13:0] gain_word_in,
	input wire logic [1:0] gain_word_load,
	input wire logic [15:0] raw_strength,
	input wire logic [15:0] raw_energy,
	input wire logic [1:0] analog_supply_settled_in,
	output logic [1:0] frontend_pin_a,
	output logic [1:0] frontend_pin_b,
	output logic [1:0] analog_regulator_on,
	output logic [3:0] amplifier_supply_select,
	output logic [13:0] gain_control_word,
	output logic [15:0] signal_strength_value,
	output logic [15:0] energy_detect_value
);
	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	logic [3:0] awaddr_r;
	logic aw_held_r;
	logic [7:0] wdata_r;
	logic w_held_r;
	logic wstrb0_r;
	logic [1:0] byp_r;
	logic [3:0] map_r;
	logic [1:0] ext_r;
	logic [1:0] analog_regulator_enable_r;
	logic [3:0] amplifier_supply_select_r;
	logic [3:0] cfg_r;
	logic [1:0] settled_m_r;
	logic [1:0] settled_r;
	logic do_write;
	logic wr_hit;
	logic [7:0] rd_byte;
	logic rd_hit;

	assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

	// Address and data are caught apart; a write lands when both are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			awaddr_r <= 4'h0;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			awaddr_r <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (do_write) begin
			aw_held_r <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_r && !s_axi_bvalid;
		end
	end

	// Only the low byte holds register bits, so only lane 0 matters
	// Data is taken whether or not the address came first, so neither order stalls
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			wdata_r <= 8'h00;
			wstrb0_r <= 1'b0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			wdata_r <= s_axi_wdata[7:0];
			wstrb0_r <= s_axi_wstrb[0]; // Lane 0 off: the write completes, no effect
			s_axi_wready <= 1'b0;
		end else if (do_write) begin
			w_held_r <= 1'b0;
		end else begin
			s_axi_wready <= !w_held_r && !s_axi_bvalid;
		end
	end

	assign wr_hit = awaddr_r[1:0] == 2'h0;

	// Write response; unmapped low address bits answer with an error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
	end

	// Read path: one read at a time, answered the cycle after address
	always_comb begin
		rd_byte = 8'h00;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			`OFF_AUX0: rd_byte = {byp_r[0], map_r[1:0], ext_r[0], analog_regulator_enable_r[0],
				settled_r[0], amplifier_supply_select_r[1:0]};
			`OFF_AUX1: rd_byte = {byp_r[1], map_r[3:2], ext_r[1], analog_regulator_enable_r[1],
				settled_r[1], amplifier_supply_select_r[3:2]};
			`OFF_PAD0: rd_byte = {cfg_r[1:0], 6'h00};
			`OFF_PAD1: rd_byte = {cfg_r[3:2], 6'h00};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h00_0000, rd_byte};
			s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_rvalid;
		end
	end

	// Settled flag comes from the regulator pins, so it is synchronised
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			settled_m_r <= 2'h0;
			settled_r <= 2'h0;
		end else begin
			settled_m_r <= analog_supply_settled_in;
			settled_r <= settled_m_r;
		end
	end

	// ----------------------------------------
	// Per transceiver logic
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : trx
			logic sel_aux;
			logic sel_pad;
			fe_pkg::radio_state_t st;
			fe_pkg::radio_state_t st_prev_r;
			logic [6:0] gcw_r;
			logic bypass;
			logic [7:0] ext_gain;
			logic pa_nxt;
			logic pb_nxt;
			logic reg_nxt;

			assign sel_aux = awaddr_r == (g ? `OFF_AUX1 : `OFF_AUX0);
			assign sel_pad = awaddr_r == (g ? `OFF_PAD1 : `OFF_PAD0);
			assign st = fe_pkg::radio_state_t'(radio_state[3*g +: 3]);

			// Software settings, each transceiver has its own copy
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					byp_r[g] <= `BYP_RST;
					map_r[2*g +: 2] <= `MAP_RST;
					ext_r[g] <= `EXT_RST;
					analog_regulator_enable_r[g] <= `ANALOG_REGULATOR_ENABLE_RST;
					amplifier_supply_select_r[2*g +: 2] <= `AMPLIFIER_SUPPLY_SELECT_RST;
					cfg_r[2*g +: 2] <= `PAD_CFG_RST;
				end else if (do_write && wstrb0_r && sel_aux) begin
					byp_r[g] <= wdata_r[`AUX_BYP];
					map_r[2*g +: 2] <= wdata_r[`AUX_MAP_HI:`AUX_MAP_LO];
					ext_r[g] <= wdata_r[`AUX_EXT];
					analog_regulator_enable_r[g] <= wdata_r[`AUX_ANALOG_REGULATOR_ENABLE];
					amplifier_supply_select_r[2*g +: 2] <= wdata_r[`AUX_AMPLIFIER_SUPPLY_SELECT_HI:`AUX_AMPLIFIER_SUPPLY_SELECT_LO];
				end else if (do_write && wstrb0_r && sel_pad) begin
					cfg_r[2*g +: 2] <= wdata_r[`PAD_CFG_HI:`PAD_CFG_LO];
				end
			end

			// Gain word: loads from the gain loop, restarts only on entry to receive
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					st_prev_r <= fe_pkg::st_reset;
					gcw_r <= `GCW_RST;
				end else begin
					st_prev_r <= st;
					if (st == fe_pkg::st_rx && st_prev_r != fe_pkg::st_rx) begin
						gcw_r <= `GCW_RST;
					end else if (gain_word_load[g]) begin
						gcw_r <= gain_word_in[7*g +: 7];
					end
				end
			end

			// Strong signal or no back-off map means the LNA is bypassed
			assign bypass = byp_r[g] && (map_r[2*g +: 2] == `MAP_NONE
				|| gcw_r <= `GCW_LIMIT);

			// External gain the readings are corrected by
			always_comb begin
				ext_gain = `GAIN_0DB;
				if (!bypass && map_r[2*g +: 2] == `MAP_9DB) begin
					ext_gain = `GAIN_9DB;
				end else if (!bypass && map_r[2*g +: 2] == `MAP_12DB) begin
					ext_gain = `GAIN_12DB;
				end
			end

			// Pin encoding per configuration; off states leave both low
			always_comb begin
				pa_nxt = 1'b0;
				pb_nxt = 1'b0;
				unique case (fe_pkg::pin_cfg_t'(cfg_r[2*g +: 2]))
					fe_pkg::pin_config_none: begin
						pa_nxt = 1'b0;
					end
					fe_pkg::pin_config_one: begin
						pa_nxt = st == fe_pkg::st_tx || (st == fe_pkg::st_rx && bypass);
						pb_nxt = st == fe_pkg::st_rx;
					end
					fe_pkg::pin_config_two: begin
						pa_nxt = st == fe_pkg::st_tx || (st == fe_pkg::st_rx && bypass);
						pb_nxt = st == fe_pkg::st_tx || (st == fe_pkg::st_rx && !bypass);
					end
					fe_pkg::pin_config_three: begin
						// Enable is the controller's pin; here off reads as bypass
						pa_nxt = st == fe_pkg::st_tx;
						pb_nxt = st == fe_pkg::st_tx || (st == fe_pkg::st_rx && !bypass);
					end
				endcase
			end

			// Regulator runs while active, in idle only when asked, never in sleep
			always_comb begin
				reg_nxt = 1'b0;
				if (!ext_r[g]) begin
					reg_nxt = st == fe_pkg::st_transmit_prepare_state || st == fe_pkg::st_tx
						|| st == fe_pkg::st_rx || (st == fe_pkg::st_idle && analog_regulator_enable_r[g]);
				end
			end

			// Outputs are registered, one cycle behind the radio state
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					frontend_pin_a[g] <= 1'b0;
					frontend_pin_b[g] <= 1'b0;
					analog_regulator_on[g] <= 1'b0;
					amplifier_supply_select[2*g +: 2] <= `AMPLIFIER_SUPPLY_SELECT_RST;
					gain_control_word[7*g +: 7] <= `GCW_RST;
					signal_strength_value[8*g +: 8] <= 8'h00;
					energy_detect_value[8*g +: 8] <= 8'h00;
				end else begin
					frontend_pin_a[g] <= pa_nxt;
					frontend_pin_b[g] <= pb_nxt;
					analog_regulator_on[g] <= reg_nxt;
					amplifier_supply_select[2*g +: 2] <= amplifier_supply_select_r[2*g +: 2];
					gain_control_word[7*g +: 7] <= gcw_r;
					signal_strength_value[8*g +: 8] <= raw_strength[8*g +: 8] - ext_gain;
					energy_detect_value[8*g +: 8] <= raw_energy[8*g +: 8] - ext_gain;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_rx_entry;
		radio_state[2:0] == 3'h5 && $past(radio_state[2:0]) != 3'h5;
	endsequence

	a_cfg_zero_low: assert property (cfg_r[1:0] == 2'h0 |=>
		!frontend_pin_a[0] && !frontend_pin_b[0]) else $error("config 0 pin high");
	a_cfg1_tx_pins: assert property (cfg_r[1:0] == 2'h1 && radio_state[2:0] == 3'h4
		|=> frontend_pin_a[0] && !frontend_pin_b[0]) else $error("config 1 tx");
	a_cfg2_tx_pins: assert property (cfg_r[1:0] == 2'h2 && radio_state[2:0] == 3'h4
		|=> frontend_pin_a[0] && frontend_pin_b[0]) else $error("config 2 tx");
	a_cfg3_rx_pins: assert property (cfg_r[1:0] == 2'h3 && radio_state[2:0] == 3'h5
		|=> !frontend_pin_a[0]) else $error("config 3 rx pin a");
	a_off_pins_low: assert property (cfg_r[1:0] == 2'h1 && radio_state[2:0] == 3'h3
		|=> !frontend_pin_a[0] && !frontend_pin_b[0]) else $error("prep pins");
	a_gcw_rx_reset: assert property (s_rx_entry |=>
		trx[0].gcw_r == `GCW_RST) else $error("gain word not restarted");
	a_lna_high_gain: assert property (cfg_r[1:0] == 2'h1 && byp_r[0] && map_r[1:0] == 2'h1
		&& trx[0].gcw_r > 7'h11 && radio_state[2:0] == 3'h5 ##0 !gain_word_load[0]
		|=> !frontend_pin_a[0] && frontend_pin_b[0]) else $error("lna mode");
	a_sleep_reg_off: assert property (radio_state[2:0] == 3'h1 |=>
		!analog_regulator_on[0]) else $error("regulator on in sleep");
	a_ext_reg_off: assert property (ext_r[0] |=> !analog_regulator_on[0])
		else $error("regulator on with external supply");
	a_byp_no_gain: assert property (trx[0].bypass |-> trx[0].ext_gain == 8'h00)
		else $error("gain in bypass");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_pin_follow: assert property ($changed(trx[1].pa_nxt) |=>
		frontend_pin_a[1] == $past(trx[1].pa_nxt)) else $error("pin stale");

	// Further encodings; config 1 rx LNA, config 2 rx bypass and config 3 tx and idle rows have their own checks
	a_cfg1_rx_lna: assert property (cfg_r[1:0] == 2'h1 && !trx[0].bypass
		&& radio_state[2:0] == 3'h5 |=> !frontend_pin_a[0] && frontend_pin_b[0])
		else $error("config 1 rx lna");
	a_cfg2_rx_byp: assert property (cfg_r[1:0] == 2'h2 && trx[0].bypass
		&& radio_state[2:0] == 3'h5 |=> frontend_pin_a[0] && !frontend_pin_b[0])
		else $error("config 2 rx bypass");
	a_cfg3_tx_pins: assert property (cfg_r[1:0] == 2'h3 && radio_state[2:0] == 3'h4
		|=> frontend_pin_a[0] && frontend_pin_b[0]) else $error("config 3 tx");
	a_cfg3_idle_low: assert property (cfg_r[1:0] == 2'h3 && radio_state[2:0] == 3'h0
		|=> !frontend_pin_a[0] && !frontend_pin_b[0]) else $error("config 3 idle");
	a_map0_bypass: assert property (byp_r[0] && map_r[1:0] == 2'h0
		|-> trx[0].bypass) else $error("map 0 not bypassed");
	a_gain_nine: assert property (!trx[0].bypass && map_r[1:0] == 2'h1 |=>
		signal_strength_value[7:0] == $past(raw_strength[7:0]) - 8'h09)
		else $error("strength not corrected");
	a_idle_reg_on: assert property (radio_state[2:0] == 3'h0 && analog_regulator_enable_r[0]
		&& !ext_r[0] |=> analog_regulator_on[0]) else $error("regulator off in idle");
	a_amplifier_supply_select_copy: assert property (1'b1 |=>
		amplifier_supply_select[1:0] == $past(amplifier_supply_select_r[1:0])) else $error("supply select");
	a_trx1_cfg0: assert property (cfg_r[3:2] == 2'h0 |=>
		!frontend_pin_a[1] && !frontend_pin_b[1]) else $error("trx1 config 0 pin high");
	a_write_resp: assert property (aw_held_r && w_held_r && !s_axi_bvalid
		|=> s_axi_bvalid) else $error("write not answered");
endmodule

// >>> fe_module_model.sv
// Behavioural model of the external frontend module and its controller enable
module fe_module_model (
	input wire logic [1:0] cfg,
	input wire logic [2:0] state,
	input wire logic pin_a,
	input wire logic pin_b,
	output logic mcu_enable,
	output logic [1:0] mode
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// Controller enable and pin decoding
	// ----------------------------------------
	// The controller, not the pins, switches the module on in config 3
	assign mcu_enable = (state == 3'h4) || (state == 3'h5);
	// Modes: 0 off, 1 LNA receive, 2 transmit, 3 bypass receive
	always_comb begin
		case (cfg)
			2'h1: mode = {pin_a, pin_b};
			2'h2: mode = {pin_a, pin_b} ^ {1'b0, pin_a};
			2'h3: begin
				// Pins alone cannot turn the module off, so the enable gates it
				if (!mcu_enable) begin
					mode = 2'h0;
				end else begin
					mode = pin_b ? {pin_a, !pin_a} : 2'h3;
				end
			end
			default: mode = 2'h0;
		endcase
	end
endmodule

// >>> rf_frontend_pin_control_bench.sv
// Self-checking bench for the frontend pin control block
module rf_frontend_pin_control_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp, fe_mode;
	logic [5:0] radio_state = 6'h00;
	logic [13:0] gain_word_in = 14'h0000, gain_control_word;
	logic [1:0] gain_word_load = 2'h0, analog_supply_settled_in = 2'h0;
	logic [15:0] raw_strength = 16'h0000, raw_energy = 16'h0000;
	logic [1:0] frontend_pin_a, frontend_pin_b, analog_regulator_on;
	logic [3:0] amplifier_supply_select;
	logic [15:0] signal_strength_value, energy_detect_value;
	logic mcu_enable;
	int fails = 0, n_checks = 0, cycles = 0;
	// Rows: config, trx0 state, aux value, expected {pin_a, pin_b}
	logic [14:0] rows [17] = '{
		{2'h0, 3'h4, 8'h00, 2'h0}, {2'h0, 3'h5, 8'h80, 2'h0},
		{2'h1, 3'h3, 8'h00, 2'h0}, {2'h1, 3'h4, 8'h00, 2'h2},
		{2'h1, 3'h5, 8'h00, 2'h1}, {2'h1, 3'h5, 8'h80, 2'h3},
		{2'h1, 3'h0, 8'h00, 2'h0}, {2'h1, 3'h1, 8'h00, 2'h0},
		{2'h1, 3'h2, 8'h00, 2'h0}, {2'h2, 3'h3, 8'h00, 2'h0},
		{2'h2, 3'h4, 8'h00, 2'h3}, {2'h2, 3'h5, 8'h00, 2'h1},
		{2'h2, 3'h5, 8'h80, 2'h2}, {2'h3, 3'h4, 8'h00, 2'h3},
		{2'h3, 3'h5, 8'hA0, 2'h1}, {2'h3, 3'h5, 8'h80, 2'h0},
		{2'h3, 3'h3, 8'h00, 2'h0}
	};

	rf_frontend_pin_control dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.radio_state, .gain_word_in, .gain_word_load, .raw_strength, .raw_energy,
		.analog_supply_settled_in, .frontend_pin_a, .frontend_pin_b, .analog_regulator_on,
		.amplifier_supply_select, .gain_control_word, .signal_strength_value,
		.energy_detect_value
	);
	fe_module_model partner (
		.cfg(2'h1), .state(radio_state[2:0]), .pin_a(frontend_pin_a[0]),
		.pin_b(frontend_pin_b[0]), .mcu_enable, .mode(fe_mode)
	);

	// ----------------------------------------
	// Clock, timeout and shared tasks
	// ----------------------------------------
	always #12.5 aclk = ~aclk;
	// Generous ceiling: the whole sequence needs well under a thousand cycles
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails++;
			complete_run();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Address and data go out together; each is dropped at its own handshake
	task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
		bit aw;
		bit w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(aw && w));
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic load_gain(input logic [13:0] g);
		gain_word_in <= g;
		gain_word_load <= 2'h1;
		tick(1);
		gain_word_load <= 2'h0;
		tick(3);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		tick(2);
		aresetn <= 1'b1;
		tick(1);
		chk(32'(amplifier_supply_select), 32'hA);
		chk(32'(gain_control_word), 32'h3FFF);
		rd(4'h0, rdat, resp);
		chk(rdat, 32'h02);
		wr(4'h4, 8'hFF, resp);
		rd(4'h4, rdat, resp);
		chk(rdat, 32'hC0);
		wr(4'h6, 8'h55, resp);
		chk(32'(resp), 32'h2);
		rd(4'h2, rdat, resp);
		chk(32'(resp), 32'h2);
		// Mid-run reset must bring the pad field back to configuration 0
		aresetn <= 1'b0;
		tick(2);
		aresetn <= 1'b1;
		tick(2);
		rd(4'h4, rdat, resp);
		chk(rdat, 32'h00);
		// Table of encodings; trx1 stays idle and unconfigured throughout
		foreach (rows[i]) begin
			wr(4'h0, rows[i][9:2], resp);
			wr(4'h4, {rows[i][14:13], 6'h00}, resp);
			radio_state <= {3'h0, rows[i][12:10]};
			tick(3);
			chk(32'({frontend_pin_a, frontend_pin_b}), 32'({1'b0, rows[i][1], 1'b0, rows[i][0]}));
		end
		// Gain word survives non-receive changes and restarts on receive entry
		wr(4'h4, 8'h40, resp);
		wr(4'h0, 8'hA0, resp);
		radio_state <= 6'h04;
		tick(3);
		load_gain(14'h0005);
		radio_state <= 6'h00;
		tick(3);
		chk(32'(gain_control_word[6:0]), 32'h05);
		radio_state <= 6'h05;
		tick(3);
		chk(32'(gain_control_word[6:0]), 32'h7F);
		raw_strength <= 16'h0050;
		raw_energy <= 16'h0005;
		load_gain(14'h0012);
		chk(32'({frontend_pin_a[0], frontend_pin_b[0]}), 32'h1);
		chk(32'(fe_mode), 32'h1);
		chk(32'(signal_strength_value[7:0]), 32'h47);
		chk(32'(energy_detect_value[7:0]), 32'hFC);
		load_gain(14'h0011);
		chk(32'({frontend_pin_a[0], frontend_pin_b[0]}), 32'h3);
		chk(32'(signal_strength_value[7:0]), 32'h50);
		wr(4'h0, 8'h40, resp);
		tick(3);
		chk(32'(signal_strength_value[7:0]), 32'h44);
		// Regulator in idle, sleep and with the external supply selected
		radio_state <= 6'h00;
		wr(4'h0, 8'h08, resp);
		tick(3);
		chk(32'(analog_regulator_on[0]), 32'h1);
		radio_state <= 6'h01;
		tick(3);
		chk(32'(analog_regulator_on[0]), 32'h0);
		radio_state <= 6'h00;
		wr(4'h0, 8'h18, resp);
		tick(3);
		chk(32'(analog_regulator_on[0]), 32'h0);
		wr(4'h0, 8'h01, resp);
		analog_supply_settled_in <= 2'h1;
		tick(4);
		chk(32'(amplifier_supply_select[1:0]), 32'h1);
		rd(4'h0, rdat, resp);
		chk(rdat, 32'h05);
		// Second transceiver drives its own pair only
		wr(4'hC, 8'h40, resp);
		radio_state <= 6'h20;
		tick(3);
		chk(32'({frontend_pin_a, frontend_pin_b}), 32'h8);
		complete_run();
	end
endmodule
